/* verilog/crp_pkg.sv */
package crp_pkg;

    // cache geometry
    localparam int TAG_W   = 19;
    localparam int ENT_W   = 6;
    localparam int LRU_W   = 6;
    localparam int DIDX_W  = 10;

    // address regions, top three bits of the cache address
    localparam logic [2:0] RGN_CACHED = 3'h0;
    localparam logic [2:0] RGN_THRU   = 3'h1;
    localparam logic [2:0] RGN_PURGE  = 3'h2;
    localparam logic [2:0] RGN_ADDR   = 3'h3;
    localparam logic [2:0] RGN_DATA   = 3'h6;
    localparam logic [2:0] RGN_IO     = 3'h7;

    // address fields
    localparam int RGN_HI = 31;
    localparam int RGN_LO = 29;
    localparam int TAG_HI = 28;
    localparam int TAG_LO = 10;
    localparam int ENT_HI = 9;
    localparam int ENT_LO = 4;
    localparam int WRD_HI = 3;
    localparam int WRD_LO = 2;
    localparam int DWY_HI = 11;
    localparam int DWY_LO = 10;

    // address-array data word fields
    localparam int AA_LRU_HI = 9;
    localparam int AA_LRU_LO = 4;
    localparam int AA_VALID  = 2;

    // cache control register bits
    localparam int CTL_EN    = 0;
    localparam int CTL_IINH  = 1;
    localparam int CTL_DINH  = 2;
    localparam int CTL_TWO   = 3;
    localparam int CTL_PURGE = 4;
    localparam int CTL_WSL   = 6;
    localparam int CTL_WSH   = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;

    // access sizes and line length
    localparam logic [1:0] SZ_BYTE   = 2'h0;
    localparam logic [1:0] SZ_WORD   = 2'h1;
    localparam logic [1:0] FILL_LAST = 2'h3;

    typedef enum logic [2:0] {S_IDLE, S_LOOK, S_MEMRD, S_FILL, S_MEMWR} crp_state_e;

    // byte enables, big-endian lane order
    function automatic logic [3:0] lane_be(input logic [1:0] sz, input logic [1:0] off);
        if (sz == SZ_BYTE)
            return 4'h8 >> off;
        if (sz == SZ_WORD)
            return off[1] ? 4'h3 : 4'hC;
        return 4'hF;
    endfunction : lane_be

    // order bits after an access to one way
    function automatic logic [5:0] lru_touch(input logic [5:0] l, input logic [1:0] w);
        unique case (w)
            2'h0: return l & 6'h07;
            2'h1: return (l & 6'h19) | 6'h20;
            2'h2: return (l & 6'h2A) | 6'h14;
            2'h3: return l | 6'h0B;
        endcase
    endfunction : lru_touch

    // replacement choice from the order bits
    function automatic logic [1:0] pick_victim(input logic [5:0] l, input logic two);
        if (two)
            return l[0] ? 2'h2 : 2'h3;
        if (l[5] && l[4] && l[3])
            return 2'h0;
        if (!l[5] && l[2] && l[1])
            return 2'h1;
        if (!l[4] && !l[2] && l[0])
            return 2'h2;
        return 2'h3;
    endfunction : pick_victim

endpackage : crp_pkg

/* verilog/crp_cache_maint.sv */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module crp_cache_maint #(
    parameter int RA_W = 8
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [RA_W-1:0]   regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdata,
    // cache bus from the cpu
    input  wire logic              cpuReq,
    input  wire logic [31:0]       cpuAddr,
    input  wire logic              cpuWr,
    input  wire logic [1:0]        cpuSize,
    input  wire logic [31:0]       cpuWdata,
    input  wire logic              cpuIfetch,
    input  wire logic              cpuTas,
    output logic                   cpuBusy,
    output logic                   cpuDone,
    output logic      [31:0]       cpuRdata,
    // internal bus to memory
    output logic                   memReq,
    output logic                   memWr,
    output logic      [31:0]       memAddr,
    output logic      [31:0]       memWdata,
    output logic      [3:0]        memBe,
    input  wire logic              memAck,
    input  wire logic [31:0]       memRdata
);

    ////////////////////////////////////////////////////////////////////////////
    // storage

    logic [crp_pkg::TAG_W-1:0] tagMem  [0:3][0:63];
    logic [63:0]               validMem [0:3];
    logic [crp_pkg::LRU_W-1:0] lruMem  [0:63];
    logic [31:0]               dataMem [0:1023];

    logic [7:0]                ctrlReg;
    crp_pkg::crp_state_e       state;
    logic [31:0]               reqAddr;
    logic [31:0]               reqWdata;
    logic [1:0]                reqSize;
    logic                      reqWr;
    logic                      reqIfetch;
    logic                      reqTas;
    logic [1:0]                vicWay;
    logic [1:0]                fillCnt;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic [2:0]                rgnIn;
    logic [2:0]                rgn;
    logic [5:0]                ent;
    logic [crp_pkg::TAG_W-1:0] reqTag;
    logic [1:0]                wsel;
    logic                      takeReq;
    logic                      purgeAll;
    logic                      cachedEn;
    logic [3:0]                hitVec;
    logic                      hit;
    logic [1:0]                hitWay;
    logic [5:0]                lruCur;
    logic [1:0]                victim;
    logic                      inhibit;
    logic                      readHit;
    logic                      hitWr;
    logic                      refill;
    logic                      lruTouchEn;
    logic [1:0]                touchWay;
    logic [crp_pkg::DIDX_W-1:0] dIdx;
    logic [31:0]               aaWord;
    logic [3:0]                beIn;
    logic [3:0]                beReq;

    assign rgnIn   = cpuAddr[crp_pkg::RGN_HI:crp_pkg::RGN_LO];
    assign rgn     = reqAddr[crp_pkg::RGN_HI:crp_pkg::RGN_LO];
    assign ent     = reqAddr[crp_pkg::ENT_HI:crp_pkg::ENT_LO];
    assign reqTag  = reqAddr[crp_pkg::TAG_HI:crp_pkg::TAG_LO];
    assign wsel    = ctrlReg[crp_pkg::CTL_WSH:crp_pkg::CTL_WSL];
    assign takeReq = cpuReq && (state == crp_pkg::S_IDLE);
    assign lruCur  = lruMem[ent];
    // data array index: way, entry, longword
    assign dIdx    = cpuAddr[crp_pkg::DWY_HI:crp_pkg::WRD_LO];
    // lane enables kept as nets: a bit-select on a call result is not portable
    assign beIn    = crp_pkg::lane_be(cpuSize, cpuAddr[1:0]);
    assign beReq   = crp_pkg::lane_be(reqSize, reqAddr[1:0]);

    // full purge is a control write with the purge bit high
    assign purgeAll = regWr && (regAddr == RA_W'(crp_pkg::REG_CTRL))
                      && regWdata[crp_pkg::CTL_PURGE];

    // region selects the operation
    assign cachedEn = (rgn == crp_pkg::RGN_CACHED) && ctrlReg[crp_pkg::CTL_EN];

    // tag compare over all four ways, even in two-way mode
    always_comb
    begin
        hitWay = 2'h0;
        for (int w = 0; w < 4; w++)
        begin
            hitVec[w] = validMem[w][ent] && (tagMem[w][ent] == reqTag);
        end
        for (int w = 3; w >= 0; w--)
        begin
            if (hitVec[w])
                hitWay = 2'(w);
        end
    end

    assign hit     = |hitVec;
    assign victim  = crp_pkg::pick_victim(lruCur, ctrlReg[crp_pkg::CTL_TWO]);
    assign inhibit = reqIfetch ? ctrlReg[crp_pkg::CTL_IINH] : ctrlReg[crp_pkg::CTL_DINH];

    // cached read paths; a test-and-set read never looks at tags
    assign readHit = cachedEn && !reqWr && !reqTas && hit;
    assign refill  = cachedEn && !reqWr && !reqTas && !hit && !inhibit;
    // writes and test-and-set write-back update a hitting way
    assign hitWr   = cachedEn && reqWr && hit;

    assign lruTouchEn = (state == crp_pkg::S_LOOK) && (readHit || hitWr || refill);
    assign touchWay   = refill ? victim : hitWay;

    // address array word: tag, order bits, valid
    assign aaWord = {3'h0, tagMem[wsel][ent], lruCur, 1'b0, validMem[wsel][ent], 2'h0};

    ////////////////////////////////////////////////////////////////////////////
    // control and status registers

    // enable bit drops on reset so a purge can follow at once
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            ctrlReg <= crp_pkg::CTRL_RST;
        else if (regWr && (regAddr == RA_W'(crp_pkg::REG_CTRL)))
            ctrlReg <= regWdata[7:0] & ~(8'h01 << crp_pkg::CTL_PURGE);
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            regRdata <= 32'h0000_0000;
        else if (regRd && (regAddr == RA_W'(crp_pkg::REG_CTRL)))
            regRdata <= {24'h00_0000, ctrlReg};
        else if (regRd && (regAddr == RA_W'(crp_pkg::REG_STAT)))
            regRdata <= {29'h0000_0000, vicWay, cpuBusy};
        else
            regRdata <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // request latch

    // held until the next request is taken
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reqAddr   <= 32'h0000_0000;
            reqWdata  <= 32'h0000_0000;
            reqSize   <= 2'h0;
            reqWr     <= 1'b0;
            reqIfetch <= 1'b0;
            reqTas    <= 1'b0;
        end
        else if (takeReq)
        begin
            reqAddr   <= cpuAddr;
            reqWdata  <= cpuWdata;
            reqSize   <= cpuSize;
            reqWr     <= cpuWr;
            reqIfetch <= cpuIfetch;
            reqTas    <= cpuTas;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address array: tags, valid bits, order bits

    // tags are not reset; software purges before use
    always_ff @(posedge clk_sys)
    begin
        if (state == crp_pkg::S_LOOK && refill)
            tagMem[victim][ent] <= reqTag;
        else if (state == crp_pkg::S_LOOK && rgn == crp_pkg::RGN_ADDR && reqWr)
            tagMem[wsel][ent] <= reqTag;
    end

    // purge beats any same-cycle update from the lookup stage
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int w = 0; w < 4; w++)
                validMem[w] <= 64'h0;
        end
        else if (purgeAll)
        begin
            for (int w = 0; w < 4; w++)
                validMem[w] <= 64'h0;
        end
        else if (state == crp_pkg::S_LOOK)
        begin
            if (rgn == crp_pkg::RGN_PURGE && reqWr)
            begin
                for (int w = 0; w < 4; w++)
                    if (hitVec[w])
                        validMem[w][ent] <= 1'b0;
            end
            else if (rgn == crp_pkg::RGN_ADDR && reqWr)
                validMem[wsel][ent] <= reqAddr[crp_pkg::AA_VALID];
            else if (refill)
                validMem[victim][ent] <= 1'b1;
        end
    end

    // read-modify-write in one edge, so back-to-back touches chain
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int e = 0; e < 64; e++)
                lruMem[e] <= 6'h00;
        end
        else if (purgeAll)
        begin
            for (int e = 0; e < 64; e++)
                lruMem[e] <= 6'h00;
        end
        else if (lruTouchEn)
            lruMem[ent] <= crp_pkg::lru_touch(lruCur, touchWay);
        else if (state == crp_pkg::S_LOOK && rgn == crp_pkg::RGN_ADDR && reqWr)
            lruMem[ent] <= reqWdata[crp_pkg::AA_LRU_HI:crp_pkg::AA_LRU_LO];
    end

    ////////////////////////////////////////////////////////////////////////////
    // data array

    // one writer; the three sources sit in exclusive states
    always_ff @(posedge clk_sys)
    begin
        if (takeReq && rgnIn == crp_pkg::RGN_DATA && cpuWr)
        begin
            for (int b = 0; b < 4; b++)
                if (beIn[b])
                    dataMem[dIdx][b*8 +: 8] <= cpuWdata[b*8 +: 8];
        end
        else if (state == crp_pkg::S_LOOK && hitWr)
        begin
            for (int b = 0; b < 4; b++)
                if (beReq[b])
                    dataMem[{hitWay, ent, reqAddr[3:2]}][b*8 +: 8]
                        <= reqWdata[b*8 +: 8];
        end
        else if (state == crp_pkg::S_FILL && memAck)
            dataMem[{vicWay, ent, memAddr[3:2]}] <= memRdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state    <= crp_pkg::S_IDLE;
            cpuBusy  <= 1'b0;
            cpuDone  <= 1'b0;
            cpuRdata <= 32'h0000_0000;
            memReq   <= 1'b0;
            memWr    <= 1'b0;
            memAddr  <= 32'h0000_0000;
            memWdata <= 32'h0000_0000;
            memBe    <= 4'h0;
            vicWay   <= 2'h0;
            fillCnt  <= 2'h0;
        end
        else
        begin
            cpuDone <= 1'b0;
            unique case (state)
                crp_pkg::S_IDLE:
                begin
                    // data array takes only the cache bus, done next edge
                    if (takeReq && rgnIn == crp_pkg::RGN_DATA)
                    begin
                        cpuDone  <= 1'b1;
                        cpuRdata <= dataMem[dIdx];
                    end
                    else if (takeReq)
                    begin
                        state   <= crp_pkg::S_LOOK;
                        cpuBusy <= 1'b1;
                    end
                end
                crp_pkg::S_LOOK:
                begin
                    if (rgn == crp_pkg::RGN_PURGE || rgn == crp_pkg::RGN_ADDR)
                    begin
                        state    <= crp_pkg::S_IDLE;
                        cpuBusy  <= 1'b0;
                        cpuDone  <= 1'b1;
                        cpuRdata <= (rgn == crp_pkg::RGN_ADDR) ? aaWord : 32'h0000_0000;
                    end
                    else if (readHit)
                    begin
                        state    <= crp_pkg::S_IDLE;
                        cpuBusy  <= 1'b0;
                        cpuDone  <= 1'b1;
                        cpuRdata <= dataMem[{hitWay, ent, reqAddr[3:2]}];
                    end
                    else if (refill)
                    begin
                        // start one past the wanted word so it arrives last
                        state   <= crp_pkg::S_FILL;
                        vicWay  <= victim;
                        fillCnt <= 2'h0;
                        memReq  <= 1'b1;
                        memWr   <= 1'b0;
                        memBe   <= 4'hF;
                        memAddr <= {reqAddr[31:4], reqAddr[3:2] + 2'h1, 2'h0};
                    end
                    else if (reqWr)
                    begin
                        // write-through after any hit update above
                        state    <= crp_pkg::S_MEMWR;
                        memReq   <= 1'b1;
                        memWr    <= 1'b1;
                        memAddr  <= reqAddr;
                        memWdata <= reqWdata;
                        memBe    <= crp_pkg::lane_be(reqSize, reqAddr[1:0]);
                    end
                    else
                    begin
                        // through, I/O, disabled, inhibited or test-and-set read
                        state   <= crp_pkg::S_MEMRD;
                        memReq  <= 1'b1;
                        memWr   <= 1'b0;
                        memAddr <= reqAddr;
                        memBe   <= crp_pkg::lane_be(reqSize, reqAddr[1:0]);
                    end
                end
                crp_pkg::S_MEMRD:
                begin
                    if (memAck)
                    begin
                        state    <= crp_pkg::S_IDLE;
                        cpuBusy  <= 1'b0;
                        cpuDone  <= 1'b1;
                        cpuRdata <= memRdata;
                        memReq   <= 1'b0;
                    end
                end
                crp_pkg::S_FILL:
                begin
                    if (memAck && fillCnt == crp_pkg::FILL_LAST)
                    begin
                        // last word goes to the array and the cpu together
                        state    <= crp_pkg::S_IDLE;
                        cpuBusy  <= 1'b0;
                        cpuDone  <= 1'b1;
                        cpuRdata <= memRdata;
                        memReq   <= 1'b0;
                    end
                    else if (memAck)
                    begin
                        fillCnt      <= fillCnt + 2'h1;
                        memAddr[3:2] <= memAddr[3:2] + 2'h1;
                    end
                end
                crp_pkg::S_MEMWR:
                begin
                    if (memAck)
                    begin
                        state   <= crp_pkg::S_IDLE;
                        cpuBusy <= 1'b0;
                        cpuDone <= 1'b1;
                        memReq  <= 1'b0;
                        memWr   <= 1'b0;
                    end
                end
                default:
                begin
                    state   <= crp_pkg::S_IDLE;
                    cpuBusy <= 1'b0;
                    memReq  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic anyValid;
    assign anyValid = |{validMem[0], validMem[1], validMem[2], validMem[3]};

    purge_all_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        purgeAll |=> !anyValid && lruCur == 6'h00)
        else $error("full purge left valid or order bits");

    enable_reset_a: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> !ctrlReg[crp_pkg::CTL_EN])
        else $error("cache enable set after reset");

    lru_way0_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lruTouchEn && touchWay == 2'h0 && !purgeAll
        |=> lruCur[5:3] == 3'h0 && lruCur[2:0] == $past(lruCur[2:0]))
        else $error("way 0 touch gave wrong order bits");

    two_way_vic_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == crp_pkg::S_LOOK && refill && ctrlReg[crp_pkg::CTL_TWO] |-> victim[1])
        else $error("two-way victim outside ways 2 and 3");

    fresh_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == crp_pkg::S_LOOK && refill && lruCur == 6'h00 |-> victim == 2'h3)
        else $error("cleared order bits did not pick way 3");

    tas_through_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == crp_pkg::S_LOOK && reqTas && !reqWr
        |=> state == crp_pkg::S_MEMRD && memReq && memAddr == reqAddr)
        else $error("test-and-set read not sent through");

    purge_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        takeReq && rgnIn == crp_pkg::RGN_PURGE |=> cpuBusy ##1 cpuDone && !cpuBusy)
        else $error("associative purge not done in 2 cycles");

    data_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        takeReq && rgnIn == crp_pkg::RGN_DATA |=> cpuDone && !cpuBusy)
        else $error("data array access not done in 1 cycle");

    refill_valid_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == crp_pkg::S_LOOK && refill && !purgeAll
        |=> validMem[vicWay][ent] && memReq && !cpuDone)
        else $error("refill valid not set ahead of data");

    fill_last_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state == crp_pkg::S_FILL && memAck && fillCnt == crp_pkg::FILL_LAST
        |-> memAddr[3:2] == reqAddr[3:2] ##1 cpuDone && !memReq)
        else $error("refill did not end on the wanted word");

endmodule : crp_cache_maint

`default_nettype wire

/* test/crp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// memory on the internal bus, answers after a random wait
module crp_mem_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // internal bus
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    output logic             memAck,
    output logic      [31:0] memRdata
);
    logic [1:0] waitCnt;

    // idle data toggles so a stale word never looks valid
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            memAck   <= 1'b0;
            memRdata <= 32'h0;
            waitCnt  <= 2'h0;
        end
        else if (memReq && !memAck && waitCnt == 2'h0)
        begin
            memAck   <= 1'b1;
            memRdata <= {~memAddr[15:0], memAddr[15:0]};
            waitCnt  <= 2'($urandom % 3);
        end
        else
        begin
            memAck   <= 1'b0;
            memRdata <= ~memRdata;
            if (waitCnt != 2'h0)
                waitCnt <= waitCnt - 2'h1;
        end
    end
endmodule : crp_mem_model

`default_nettype wire

/* test/cache_replacement_purge_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module cache_replacement_purge_access_tb;
    logic clk_sys, sys_rst, regWr, regRd, cpuReq, cpuWr, cpuIfetch, cpuTas;
    logic cpuBusy, cpuDone, memReq, memWr, memAck;
    logic [7:0] regAddr;
    logic [1:0] cpuSize;
    logic [3:0] memBe;
    logic [31:0] regWdata, regRdata, cpuAddr, cpuWdata, cpuRdata, memAddr, memWdata, memRdata;
    logic [31:0] v, a;
    logic [18:0] tg [4];
    logic [5:0] e;
    int n_fail, checked, q[$];
    logic test_and_set_instruction, ife;
    logic [31:0] b, dw, wAddr, wData;
    logic [3:0] wBe;

    crp_cache_maint dut (.clk_sys, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .cpuReq, .cpuAddr, .cpuWr, .cpuSize, .cpuWdata, .cpuIfetch, .cpuTas, .cpuBusy, .cpuDone,
        .cpuRdata, .memReq, .memWr, .memAddr, .memWdata, .memBe, .memAck, .memRdata);
    crp_mem_model mem (.clk_sys, .sys_rst, .memReq, .memAddr, .memAck, .memRdata);

    // last write that memory accepted, for the write-through checks
    always @(posedge clk_sys)
        if (memReq && memWr && memAck)
        begin
            wAddr <= memAddr;
            wData <= memWdata;
            wBe <= memBe;
        end

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task complete_run;
        $display("compares %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task rw(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1; regAddr <= ad; regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : rw

    task rr(input logic [7:0] ad);
        @(posedge clk_sys);
        regRd <= 1'b1; regAddr <= ad;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask : rr

    // one cache-bus access, fields held until done
    task cpu(input logic w, input logic [31:0] ad, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        cpuReq <= 1'b1; cpuWr <= w; cpuAddr <= ad; cpuWdata <= d;
        cpuTas <= test_and_set_instruction;
        cpuIfetch <= ife;
        @(posedge clk_sys);
        cpuReq <= 1'b0;
        #1 i = 0;
        // only the data window leaves the bus free
        chk(32'(cpuBusy), 32'(ad[31:29] != 3'h6));
        while (cpuDone !== 1'b1 && i < 60)
        begin
            @(posedge clk_sys);
            #1 i++;
        end
        if (cpuDone !== 1'b1)
        begin
            n_fail++;
            complete_run();
        end
        v = cpuRdata;
    endtask : cpu

    // an access moves its way to the young end of the queue
    task touch(input int w);
        int k;
        k = 0;
        while (k < 3 && q[k] != w)
            k++;
        q.delete(k);
        q.push_back(w);
    endtask : touch

    // read miss: model victim is the oldest way in the queue
    task miss(input logic [31:0] ad);
        cpu(1'b0, ad, 32'h0);
        chk(v, {~ad[15:0], ad[15:0]});
        rr(8'h04);
        chk(v, 32'(q[0] << 1));
        q.push_back(q.pop_front());
    endtask : miss

    initial
    begin
        {sys_rst, regWr, regRd, cpuReq, cpuWr, cpuIfetch, cpuTas} = 7'h40;
        {regAddr, regWdata, cpuAddr, cpuWdata} = '0;
        cpuSize = 2'h2;
        test_and_set_instruction = 1'b0;
        ife = 1'b0;
        void'($urandom(30));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rr(8'h00);
        chk(v, 32'h0);
        rw(8'h00, 32'h10);
        rw(8'h00, 32'h01);
        rr(8'h00);
        chk(v, 32'h1);
        q = '{3, 2, 1, 0};
        e = 6'($urandom);
        for (int k = 0; k < 4; k++)
        begin
            tg[k] = 19'({$urandom, 2'(k)});
            miss({3'h0, tg[k], e, 4'h0});
        end
        // way 0 holds the last fill; its word 1 shows in the data window
        a = {3'h0, tg[3], e, 4'h4};
        cpu(1'b0, 32'hC0000004 | {e, 4'h0}, 32'h0);
        chk(v, {~a[15:0], a[15:0]});
        // hit on the way-3 line makes way 2 the oldest
        a = {3'h0, tg[0], e, 4'h0};
        cpu(1'b0, a, 32'h0);
        chk(v, {~a[15:0], a[15:0]});
        touch(3);
        miss({3'h0, ~tg[0], e, 4'h0});
        rw(8'h00, 32'h41);
        cpu(1'b0, {3'h3, 19'h0, e, 4'h0}, 32'h0);
        chk(v, {3'h0, tg[2], 6'h1E, 4'h4});
        cpu(1'b1, {3'h2, tg[2], e, 4'h0}, 32'h0);
        cpu(1'b0, {3'h3, 19'h0, e, 4'h0}, 32'h0);
        chk(v & 32'h4, 32'h0);
        // the stale tag left in way 1 must miss
        miss({3'h0, tg[2], e, 4'h0});
        a = $urandom;
        cpu(1'b1, 32'hC0000C00 | {e, 4'h0}, a);
        cpu(1'b0, 32'hC0000C00 | {e, 4'h0}, 32'h0);
        chk(v, a);
        // write hit lands in way 3 and goes through to memory
        b = {3'h0, tg[0], e, 4'h0};
        dw = $urandom;
        cpu(1'b1, b, dw);
        chk(wData, dw);
        chk(wAddr, b);
        chk(32'(wBe), 32'hF);
        touch(3);
        cpu(1'b0, b, 32'h0);
        chk(v, dw);
        // test-and-set reads past the hit, writes back into the hit way
        test_and_set_instruction = 1'b1;
        cpu(1'b0, b, 32'h0);
        chk(v, {~b[15:0], b[15:0]});
        dw = v | 32'h8000_0000;
        cpu(1'b1, b, dw);
        chk(wData, dw);
        test_and_set_instruction = 1'b0;
        cpu(1'b0, b, 32'h0);
        chk(v, dw);
        // inhibited misses go straight through and leave the line alone
        b = {3'h0, ~tg[1], e, 4'h0};
        rw(8'h00, 32'h45);
        cpu(1'b0, b, 32'h0);
        chk(v, {~b[15:0], b[15:0]});
        rr(8'h04);
        chk(v, 32'h2);
        rw(8'h00, 32'h43);
        ife = 1'b1;
        cpu(1'b0, b, 32'h0);
        chk(v, {~b[15:0], b[15:0]});
        rr(8'h04);
        chk(v, 32'h2);
        ife = 1'b0;
        miss(b);
        // address array write: tag and valid from the address, zero order bits
        cpu(1'b1, {3'h3, tg[3], e, 4'h4}, 32'h0);
        cpu(1'b0, {3'h3, 19'h0, e, 4'h0}, 32'h0);
        chk(v, {3'h0, tg[3], 6'h00, 4'h4});
        a = {3'h0, tg[2], e, 4'h0};
        cpu(1'b0, {3'h0, tg[3], e, 4'h0}, 32'h0);
        chk(v, {~a[15:0], a[15:0]});
        // two-way mode after a purge: ways 3 and 2 only, ways 0 and 1 as RAM
        rw(8'h00, 32'h00);
        rw(8'h00, 32'h10);
        rw(8'h00, 32'h09);
        dw = $urandom;
        cpu(1'b1, 32'hC0000000 | {e, 4'h0}, dw);
        q = '{3, 2};
        miss({3'h0, tg[1], e, 4'h0});
        miss({3'h0, tg[2], e, 4'h0});
        miss({3'h0, tg[3], e, 4'h0});
        cpu(1'b0, 32'hC0000000 | {e, 4'h0}, 32'h0);
        chk(v, dw);
        complete_run();
    end
endmodule : cache_replacement_purge_access_tb

`default_nettype wire
